// ===== inc/gobg_pkg.sv
// constants shared by the option bus glue block
package gobg_pkg;
  // strobe slot numbers, index = {a7, a6, a3}
  localparam logic [2:0] STB_CTRL   = 3'h0;   // controller select
  localparam logic [2:0] STB_PARAM  = 3'h1;   // parameter port
  localparam logic [2:0] STB_STATUS = 3'h2;   // status port
  localparam logic [2:0] STB_DIAGNOSTIC_LATCH_BIT   = 3'h3;   // diagnostic latch
  // address bit positions
  localparam int A_SEL0 = 3;                  // strobe index bit 0
  localparam int A_SEL1 = 6;                  // strobe index bit 1
  localparam int A_SEL2 = 7;                  // strobe index bit 2
  localparam int A_HIT  = 8;                  // port hit qualifier
  localparam int A_Z12  = 12;                 // must be low
  localparam int A_Z13  = 13;                 // must be low
  localparam int A_ROMCE = 18;                // rom chip select line
  // sizes
  localparam int ROM_BYTES = 65536;           // firmware rom
  localparam int RAM_BYTES = 2048;            // working ram
  localparam int ADDR_W    = 20;              // host address width
  // reset values
  localparam logic DIV_RST  = 1'b0;           // divider start
  localparam logic DIAGNOSTIC_LATCH_BIT_RST = 1'b0;           // latch start
  localparam logic [7:0] STATUS_CONST = 8'h42; // bits 1 and 6 high
endpackage

// ===== hw/gobg_glue.sv
// option board bus glue: decode, buffer control, ports, clock divider
`timescale 1ns/10ps
`default_nettype none
module gobg_glue (
  input  wire logic                        clk,                   // 40 MHz system clock
  input  wire logic                        rstn,                  // sync reset, active low
  input  wire logic [gobg_pkg::ADDR_W-1:0] host_addr,             // host address pins
  input  wire logic                        io_segment_select,     // io segment, low active
  input  wire logic                        common_segment_select, // common segment, low active
  input  wire logic                        block_zero_select,     // block 0, low active
  input  wire logic                        block_one_select,      // block 1, low active
  input  wire logic                        block_three_select,    // block 3, low active
  input  wire logic                        ram_disable_input,     // high when nv board fitted
  input  wire logic                        host_data_enable_n,    // host data enable
  input  wire logic                        host_rd_n,             // host read strobe
  input  wire logic                        host_wr_n,             // host write strobe
  input  wire logic                        host_clock,            // host clock pin
  input  wire logic                        host_reset,            // host reset, high active
  input  wire logic [7:0]                  host_data_in,          // host data bus in
  output logic [7:0]                       host_data_out,         // data driven to host
  output logic                             host_data_oe_n,        // low while driving host
  input  wire logic [7:0]                  ctrl_data_in,          // controller data out
  output logic [7:0]                       ctrl_data_out,         // data to controller
  output logic [2:0]                       register_select,       // controller register select
  output logic                             ctrl_cs_n,             // controller select
  output logic                             ctrl_rd_n,             // buffered read
  output logic                             ctrl_wr_n,             // buffered write
  output logic                             ctrl_clk,              // host clock / 2
  output logic                             ctrl_reset,            // buffered reset
  input  wire logic                        ctrl_int_n,            // controller interrupt
  output logic                             host_int_o,            // open drain: drive low
  output logic                             host_int_oe_n,         // low while pulling low
  input  wire logic                        controller_trigger_out, // controller trigger pin
  input  wire logic [7:0]                  switch_in,             // parameter switches
  input  wire logic                        power_failing_flag,    // power failing interrupt
  output logic                             rom_oe_n,              // rom output enable
  output logic                             rom_ce_n,              // rom chip enable
  output logic                             ram_enable_n,          // ram enable
  output logic                             data_buffer_enable_n,  // data buffer enable
  output logic                             option_port_hit_n,     // port hit
  output logic [7:0]                       port_strobe_n,         // decoded strobes
  output logic                             diagnostic_latch_bit   // diagnostic_latch_bit latch
);
  import gobg_pkg::*;

  // ==========================================
  // input synchronisers (buffered host signals)
  // ==========================================
  // every pin passes two flops before any logic looks at it;
  // the host bus runs on its own clock, so a single flop could hand a
  // metastable level to the decode; the price is two cycles of delay
  // on every path from pin to output
  localparam int NS = ADDR_W + 16;           // synchronised bit count
  logic [NS-1:0] s1;                         // first stage
  logic [NS-1:0] s2;                         // second stage
  logic [NS-1:0] raw;                        // pin vector
  assign raw = {host_addr, io_segment_select, common_segment_select, block_zero_select,
                block_one_select, block_three_select, ram_disable_input, host_data_enable_n,
                host_rd_n, host_wr_n, host_clock, host_reset, ctrl_int_n,
                controller_trigger_out, power_failing_flag, 2'h0};
  // buffer every pin through two flops; address buffers never gated
  always_ff @(posedge clk) begin
    s1 <= raw;
    s2 <= s1;
  end
  logic [ADDR_W-1:0] ba;                      // buffered address
  logic io_n, com_n, b0_n, b1_n, b3_n, rdis, den_n, rd_n, wr_n, hclk, hrst, int_n, trg, pwr;
  assign {ba, io_n, com_n, b0_n, b1_n, b3_n, rdis, den_n, rd_n, wr_n, hclk, hrst, int_n,
          trg, pwr} = s2[NS-1:2];
  logic [7:0] sw2;                           // switch sync stage 2
  logic [7:0] sw1;                           // switch sync stage 1
  logic [7:0] bd2;                           // data sync stage 2
  logic [7:0] bd1;                           // data sync stage 1
  logic [7:0] cd2;                           // controller data stage 2
  logic [7:0] cd1;                           // controller data stage 1
  // data-like inputs get the same two stages, so they line up in time
  // with the decode that says when they matter
  always_ff @(posedge clk) begin
    sw1 <= switch_in;
    sw2 <= sw1;
    bd1 <= host_data_in;
    bd2 <= bd1;
    cd1 <= ctrl_data_in;
    cd2 <= cd1;
  end

  // ==========================================
  // address decode
  // ==========================================
  // primary decode: one strobe of eight, picked by three address bits,
  // only while both high block bits, the io segment and block zero are low;
  // kept combinational so the data steering sees it one cycle before the
  // registered strobes leave the block
  logic       dec_en;                        // decoder enabled
  logic [2:0] sel;                           // strobe index
  logic [7:0] stb_n;                         // strobes
  logic       hit_n;                         // port hit
  always_comb begin
    dec_en = ~ba[A_Z12] & ~ba[A_Z13] & ~io_n & ~b0_n;
    sel    = {ba[A_SEL2], ba[A_SEL1], ba[A_SEL0]};
    stb_n  = 8'hff;
    if (dec_en) begin
      stb_n[sel] = 1'b0;
    end
    hit_n = ~(dec_en & ~ba[A_HIT]);
  end

  // ==========================================
  // registered enables and strobes
  // ==========================================
  // every enable and strobe leaves the block from a flop, so no decode
  // glitch can reach a memory or the controller; all but rom_ce_n idle high,
  // which keeps the data buffer shut whenever nothing is selected
  logic       next_rom_oe_n, next_rom_ce_n, next_ram_en_n, next_dben_n; // next enable levels
  always_comb begin
    next_rom_oe_n = ~(~com_n & (~b0_n | ~b1_n));
    next_rom_ce_n = ~ba[A_ROMCE];
    next_ram_en_n = ~(~rdis & ~b3_n & ~com_n);
    next_dben_n   = ~(~den_n & (~hit_n | ~com_n));
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rom_oe_n             <= 1'b1;
      rom_ce_n             <= 1'b1;
      ram_enable_n         <= 1'b1;
      data_buffer_enable_n <= 1'b1;
      option_port_hit_n    <= 1'b1;
      port_strobe_n        <= 8'hff;
      register_select      <= 3'h0;
      ctrl_rd_n            <= 1'b1;
      ctrl_wr_n            <= 1'b1;
      ctrl_reset           <= 1'b1;
    end else begin
      rom_oe_n             <= next_rom_oe_n;
      rom_ce_n             <= next_rom_ce_n;
      ram_enable_n         <= next_ram_en_n;
      data_buffer_enable_n <= next_dben_n;
      option_port_hit_n    <= hit_n;
      port_strobe_n        <= stb_n;
      register_select      <= ba[2:0];
      ctrl_rd_n            <= rd_n;
      ctrl_wr_n            <= wr_n;
      ctrl_reset           <= hrst;
    end
  end
  assign ctrl_cs_n = port_strobe_n[STB_CTRL];

  // ==========================================
  // clock divider and diagnostic latch
  // ==========================================
  // the host clock is sampled as data; its rising edge, found against the
  // previous sample, flips the divided clock, so the controller clock runs
  // at half the host rate with a jitter of one system clock
  // the diagnostic_latch_bit bit is taken on the falling edge of its strobe, qualified by
  // the write strobe so that a read of the same slot cannot disturb it
  logic hclk_d, diagnostic_latch_bit_stb_d;                  // edge history
  logic next_div, next_diagnostic_latch_bit;                 // next values
  always_comb begin
    next_div  = ctrl_clk;
    next_diagnostic_latch_bit = diagnostic_latch_bit;
    if (hclk & ~hclk_d) begin
      next_div = ~ctrl_clk;
    end
    if (~port_strobe_n[STB_DIAGNOSTIC_LATCH_BIT] & diagnostic_latch_bit_stb_d & ~wr_n) begin
      next_diagnostic_latch_bit = bd2[0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_clk             <= DIV_RST;
      diagnostic_latch_bit <= DIAGNOSTIC_LATCH_BIT_RST;
      hclk_d               <= 1'b0;
      diagnostic_latch_bit_stb_d           <= 1'b1;
    end else begin
      ctrl_clk             <= next_div;
      diagnostic_latch_bit <= next_diagnostic_latch_bit;
      hclk_d               <= hclk;
      diagnostic_latch_bit_stb_d           <= port_strobe_n[STB_DIAGNOSTIC_LATCH_BIT];
    end
  end

  // ==========================================
  // read ports and data steering
  // ==========================================
  // the two input ports and the controller read path share the host
  // data bus; the block drives it only while a read hits one of them,
  // rom and ram put their own data on the bus
  // the controller sees the data bus with its bits in reverse order
  logic [7:0] param_word, status_word, rev_ctrl, next_dout, next_ctrl_dout;
  logic       next_oe_n;
  always_comb begin
    param_word  = {trg, sw2[6:0]};
    status_word = STATUS_CONST;
    status_word[0] = pwr;
    status_word[2] = trg;
    status_word[3] = sw2[7];
    status_word[4] = sw2[6];
    status_word[5] = sw2[5];
    status_word[7] = diagnostic_latch_bit;
    for (int i = 0; i < 8; i++) begin
      rev_ctrl[i] = cd2[7-i];
      next_ctrl_dout[i] = bd2[7-i];
    end
    next_dout = 8'h00;
    next_oe_n = 1'b1;
    if (~rd_n & ~next_dben_n) begin
      next_oe_n = 1'b0;
      if (~stb_n[STB_PARAM]) begin
        next_dout = param_word;
      end else if (~stb_n[STB_STATUS]) begin
        next_dout = status_word;
      end else if (~stb_n[STB_CTRL]) begin
        next_dout = rev_ctrl;
      end else begin
        next_oe_n = 1'b1;                              // memories drive their own data
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_data_out  <= 8'h00;
      host_data_oe_n <= 1'b1;
      ctrl_data_out  <= 8'h00;
    end else begin
      host_data_out  <= next_dout;
      host_data_oe_n <= next_oe_n;
      ctrl_data_out  <= next_ctrl_dout;
    end
  end

  // interrupt passes as open drain: drive low only
  // the pin is never driven high, an outside pull-up lifts it
  assign host_int_o    = 1'b0;
  assign host_int_oe_n = int_n;

  // ==========================================
  // checks
  // ==========================================
  // all checks sleep while rstn is low: the sync stages carry no reset,
  // so their first samples after power-up may still be unknown
  // each property looks one cycle back, across the output flops, except AST_INT, which looks two cycles back

  // two steps of a diagnostic_latch_bit write: strobe seen high, then low with write low
  sequence diagnostic_latch_bit_strobe_fall_s;
    port_strobe_n[STB_DIAGNOSTIC_LATCH_BIT] ##1 (!port_strobe_n[STB_DIAGNOSTIC_LATCH_BIT] && !wr_n);
  endsequence

  // one rise of the host clock as seen after the sync stages
  sequence host_clock_rise_s;
    hclk && !hclk_d;
  endsequence

  // no decode, no strobe
  AST_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    !$past(dec_en) |-> port_strobe_n == 8'hff) else $error("strobe without decode");

  // a decode gives exactly one strobe
  AST_ONEHOT: assert property (@(posedge clk) disable iff (!rstn)
    $past(dec_en) |-> $onehot(~port_strobe_n)) else $error("strobe not one of eight");

  // port hit only on a decode with the hit address bit low
  AST_HIT: assert property (@(posedge clk) disable iff (!rstn)
    !option_port_hit_n |-> $past(dec_en && !ba[A_HIT])) else $error("port hit without decode");

  // the data buffer never opens without the host data enable
  AST_DBEN: assert property (@(posedge clk) disable iff (!rstn)
    !data_buffer_enable_n |-> !$past(den_n)) else $error("buffer open without den");

  // rom output enable only in the common segment, block zero or one
  AST_ROMOE: assert property (@(posedge clk) disable iff (!rstn)
    !rom_oe_n |-> $past(!com_n && (!b0_n || !b1_n))) else $error("rom enabled outside its blocks");

  // rom chip enable is the inverted high address bit
  AST_ROMCE: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> rom_ce_n == !$past(ba[A_ROMCE])) else $error("rom chip enable wrong");

  // ram enable only with the disable low, block three and common segment
  AST_RAM_ENABLE_N: assert property (@(posedge clk) disable iff (!rstn)
    !ram_enable_n |-> $past(!rdis && !b3_n && !com_n)) else $error("ram enabled while not selected");

  // the block drives host data only on a read of one of its own ports
  AST_RDATA: assert property (@(posedge clk) disable iff (!rstn)
    !host_data_oe_n |-> !data_buffer_enable_n && $past(!rd_n) &&
      !(port_strobe_n[STB_PARAM] && port_strobe_n[STB_STATUS] && port_strobe_n[STB_CTRL]))
    else $error("host data driven outside a port read");

  // a diagnostic_latch_bit write lands buffered data bit 0 in the latch
  AST_DIAGNOSTIC_LATCH_BIT_TAKE: assert property (@(posedge clk) disable iff (!rstn)
    diagnostic_latch_bit_strobe_fall_s |=> diagnostic_latch_bit == $past(bd2[0])) else $error("diagnostic_latch_bit bit not taken");

  // between writes the diagnostic_latch_bit bit holds
  AST_DIAGNOSTIC_LATCH_BIT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    port_strobe_n[STB_DIAGNOSTIC_LATCH_BIT] |=> $stable(diagnostic_latch_bit)) else $error("diagnostic_latch_bit changed");

  // every host clock rise flips the divided clock
  AST_DIV_STEP: assert property (@(posedge clk) disable iff (!rstn)
    host_clock_rise_s |=> ctrl_clk != $past(ctrl_clk)) else $error("divider missed a host clock rise");

  // without a rise the divided clock holds
  AST_DIV_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !(hclk && !hclk_d) |=> $stable(ctrl_clk)) else $error("divider moved without a host clock rise");

  // interrupt follows the controller pin after the two sync stages, never driven high
  AST_INT: assert property (@(posedge clk) disable iff (!rstn)
    host_int_oe_n == $past(ctrl_int_n, 2) && !host_int_o) else $error("interrupt not passed");
endmodule
`default_nettype wire

// ===== sim/gobg_host_model.sv
// host side model: free running host clock and host reset line
`timescale 1ns/10ps
`default_nettype none
module gobg_host_model (
  output logic     host_clock, // host clock, about 6.7 MHz
  output logic     host_reset, // host reset, high active
  input  wire logic reset_req  // bench asks for a host reset
);
  // ==========
  // clock source
  // processor clock runs free, unrelated in phase to clk
  initial host_clock = 1'b0;
  always #74.6 host_clock = ~host_clock;
  // reset only when the bench asks, so the divider keeps running
  assign host_reset = reset_req;
endmodule
`default_nettype wire

// ===== sim/gobg_glue_tb.sv
// self-checking bench for the option bus glue
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module gobg_glue_tb;
  import gobg_pkg::*;
  // ==========
  // bench signals
  logic [ADDR_W-1:0] host_addr = '0;                  // host address
  logic clk = 1'b0, rstn = 1'b0, reset_req = 1'b0;    // clock, resets
  logic io_segment_select = 1'b1, common_segment_select = 1'b1; // segments
  logic block_zero_select = 1'b1, block_one_select = 1'b1, block_three_select = 1'b1;
  logic ram_disable_input = 1'b0, host_data_enable_n = 1'b1; // ram off, data enable
  logic host_rd_n = 1'b1, host_wr_n = 1'b1, ctrl_int_n = 1'b1; // strobes, irq
  logic controller_trigger_out = 1'b1, power_failing_flag = 1'b1; // status sources
  logic [7:0] host_data_in = '0, ctrl_data_in = '0, switch_in = 8'ha5; // data sources
  logic host_clock, host_reset, host_data_oe_n, ctrl_cs_n, ctrl_rd_n, ctrl_wr_n;
  logic ctrl_clk, ctrl_reset, host_int_o, host_int_oe_n, rom_oe_n, rom_ce_n;
  logic ram_enable_n, data_buffer_enable_n, option_port_hit_n, diagnostic_latch_bit;
  logic [7:0] host_data_out, ctrl_data_out, port_strobe_n, sw; // data outputs
  logic [2:0] register_select;                        // controller register select
  int mismatches = 0, n_compared = 0, hc = 0, cc = 0; // counters
  // select sets {io, common, block0, block1, block3}; controls {den, rd, wr}
  localparam logic [4:0] S_IDLE = 5'h1f, S_IO = 5'h0b, S_COM = 5'h17;
  localparam logic [2:0] C_IDLE = 3'h7, C_DEN = 3'h3, C_RD = 3'h1, C_WR = 3'h2;
  // ==========
  // design, host model, clock
  gobg_glue dut (.clk, .rstn, .host_addr, .io_segment_select, .common_segment_select,
    .block_zero_select, .block_one_select, .block_three_select, .ram_disable_input,
    .host_data_enable_n, .host_rd_n, .host_wr_n, .host_clock, .host_reset, .host_data_in,
    .host_data_out, .host_data_oe_n, .ctrl_data_in, .ctrl_data_out, .register_select,
    .ctrl_cs_n, .ctrl_rd_n, .ctrl_wr_n, .ctrl_clk, .ctrl_reset, .ctrl_int_n, .host_int_o,
    .host_int_oe_n, .controller_trigger_out, .switch_in, .power_failing_flag, .rom_oe_n,
    .rom_ce_n, .ram_enable_n, .data_buffer_enable_n, .option_port_hit_n, .port_strobe_n,
    .diagnostic_latch_bit);
  gobg_host_model host (.host_clock, .host_reset, .reset_req);
  always #12.5 clk = ~clk;                            // 40 MHz
  always @(posedge host_clock) hc++;                  // host clock rises
  always @(posedge ctrl_clk) cc++;                    // divided clock rises
  // ==========
  // bus access: drive one host cycle, let syncs and latch settle
  task put(input logic [19:0] a, input logic [4:0] s, input logic [2:0] c, input logic [7:0] d);
    @(posedge clk); #2;
    host_addr = a;
    {io_segment_select, common_segment_select, block_zero_select} = s[4:2];
    {block_one_select, block_three_select} = s[1:0];
    {host_data_enable_n, host_rd_n, host_wr_n} = c;
    host_data_in = d;
    repeat (5) @(posedge clk); #2;
  endtask
  // address of a port slot, index = {a7, a6, a3}
  function automatic logic [19:0] slot(input logic [2:0] i);
    return 20'h40000 | {12'h000, i[2], i[1], 2'h0, i[0], 3'h0};
  endfunction
  // nothing decoded: no strobe, hit or buffer enable
  task quiet;
    `CHK({port_strobe_n, option_port_hit_n, data_buffer_enable_n}, 10'h3ff)
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (5) @(posedge clk); #2;
    quiet;
    `CHK({ctrl_clk, diagnostic_latch_bit}, 2'b00)
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      put(slot(i[2:0]), S_IO, C_DEN, 8'h00);
      `CHK(port_strobe_n, ~(8'h01 << i))
      `CHK({option_port_hit_n, data_buffer_enable_n}, 2'b00)
      `CHK(ctrl_cs_n, (i != 0))
    end
    put(slot(3'h1) | 20'h01000, S_IO, C_DEN, 8'h00); quiet;
    put(slot(3'h1) | 20'h02000, S_IO, C_DEN, 8'h00); quiet;
    put(slot(3'h1), 5'h0f, C_DEN, 8'h00); quiet;
    put(slot(3'h1) | 20'h00100, S_IO, C_DEN, 8'h00);
    `CHK({port_strobe_n[1], option_port_hit_n, data_buffer_enable_n}, 3'b011)
    $display("decode test done");
    put(20'h80000, S_COM, C_DEN, 8'h00);
    `CHK({data_buffer_enable_n, rom_oe_n, rom_ce_n, ram_enable_n}, 4'b0111)
    put(20'hc0000, 5'h13, C_IDLE, 8'h00);
    `CHK({data_buffer_enable_n, rom_oe_n, rom_ce_n}, 3'b100)
    put(20'h80000, 5'h15, C_IDLE, 8'h00);
    `CHK({rom_oe_n, rom_ce_n}, 2'b01)
    put(20'h88000, 5'h16, C_IDLE, 8'h00);
    `CHK(ram_enable_n, 1'b0)
    ram_disable_input = 1'b1;
    put(20'h88000, 5'h16, C_IDLE, 8'h00);
    `CHK({ram_enable_n, port_strobe_n}, 9'h1ff)
    $display("memory test done");
    put(slot(STB_DIAGNOSTIC_LATCH_BIT), S_IO, C_WR, 8'h01);
    put(slot(STB_DIAGNOSTIC_LATCH_BIT), S_IDLE, C_IDLE, 8'h00);
    `CHK(diagnostic_latch_bit, 1'b1)
    put(slot(STB_DIAGNOSTIC_LATCH_BIT), S_IO, C_WR, 8'hfe);
    `CHK(diagnostic_latch_bit, 1'b0)
    put(slot(STB_DIAGNOSTIC_LATCH_BIT), S_IDLE, C_IDLE, 8'h00);
    put(slot(STB_DIAGNOSTIC_LATCH_BIT), S_IO, C_WR, 8'h01);
    put(slot(STB_PARAM), S_IO, C_RD, 8'h00);
    sw = switch_in;
    `CHK({host_data_oe_n, host_data_out}, {1'b0, controller_trigger_out, sw[6:0]})
    controller_trigger_out = 1'b0;
    power_failing_flag = 1'b0;
    put(slot(STB_STATUS), S_IO, C_RD, 8'h00);
    `CHK(host_data_out, {1'b1, 1'b1, sw[5], sw[6], sw[7], controller_trigger_out, 1'b1, power_failing_flag})
    $display("port test done");
    put(slot(STB_CTRL) | 20'h5, S_IO, C_WR, 8'h01);
    `CHK({ctrl_cs_n, ctrl_wr_n, register_select, ctrl_data_out}, {5'h05, 8'h80})
    ctrl_data_in = 8'h03;
    ctrl_int_n = 1'b0;
    put(slot(STB_CTRL) | 20'h2, S_IO, C_RD, 8'h00);
    `CHK({ctrl_rd_n, register_select, host_data_oe_n, host_data_out}, {5'h04, 8'hc0})
    `CHK({host_int_o, host_int_oe_n}, 2'b00)
    ctrl_int_n = 1'b1;
    reset_req = 1'b1;
    put(20'h00000, S_IDLE, C_IDLE, 8'h00);
    `CHK({host_int_oe_n, ctrl_reset, ctrl_rd_n}, 3'b111)
    reset_req = 1'b0;
    put(20'h00000, S_IDLE, C_IDLE, 8'h00);
    `CHK(ctrl_reset, 1'b0)
    $display("controller test done");
    hc = 0;
    cc = 0;
    repeat (400) @(posedge clk);
    `CHK((hc - 2 * cc) inside {[-2:2]}, 1'b1)
    $display("divider test done");
    complete_run;
  end
  // hang guard
  initial begin
    #2000000;
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire
